/* File: logic/id_readback_and_gamma_split_off.v */
`timescale 1ns/1ns
`default_nettype none
`include "idcmd_regs.vh"
module id_readback_and_gamma_split_off #(
    parameter [7:0] MAKER_ID   = 8'h11,  // Arbitrary value
    parameter [7:0] VERSION_ID = 8'h22,  // Arbitrary value
    parameter [7:0] PART_ID    = 8'h33   // Arbitrary value
) (
    // Clock, hardware reset and power-on
    input  wire        REF_CLK,
    input  wire        RST_N,
    input  wire        POWER_ON,
    // Host system bus
    input  wire        CMD_DATA_SELECT,
    input  wire        WRITE_STROBE_N,
    input  wire        READ_STROBE_N,
    input  wire [17:0] DATA_IN,
    // Strap pins
    input  wire        RGB_CFG_PIN_HI,
    input  wire        RGB_CFG_PIN_LO,
    // Read-back byte and gamma state
    output reg  [7:0]  DATA_OUT,
    output reg         DATA_OE,
    output reg         SPLIT_GAMMA_EN,
    output reg         GAMMA_CURVE_ZERO_SPLIT
);
    // ==========================================================
    // Pin synchronisers
    // Every pin but RST_N passes two flip-flops before logic reads it; the host
    // bus is slow next to REF_CLK, so the extra latency costs nothing.
    wire       wr_rise;
    wire       rd_level;
    wire       rd_fall;
    wire       rd_rise;
    reg        dcx_meta_ff;
    reg        dcx_ff;
    reg [7:0]  din_meta_ff;
    reg [7:0]  din_ff;
    reg [1:0]  cfg_meta_ff;
    reg [1:0]  cfg_ff;
    reg        por_meta_ff;
    reg        por_ff;
    reg        por_prev_ff;

    // Only the end of a write strobe matters; its level and fall are unused
    strobe_sync u_wr_sync (
        .clk      (REF_CLK),
        .rst_n    (RST_N),
        .async_in (WRITE_STROBE_N),
        .level_ff (),
        .rise     (wr_rise),
        .fall     ()
    );

    // Both read edges matter: the fall presents a byte, the rise ends it
    strobe_sync u_rd_sync (
        .clk      (REF_CLK),
        .rst_n    (RST_N),
        .async_in (READ_STROBE_N),
        .level_ff (rd_level),
        .rise     (rd_rise),
        .fall     (rd_fall)
    );

    // Only the low byte is captured; upper lines never reach logic.
    // These stages carry no reset: reset is held long enough to flush
    // them, and a reset on the first stage would only add a false edge.
    always @(posedge REF_CLK) begin
        dcx_meta_ff <= CMD_DATA_SELECT;
        dcx_ff      <= dcx_meta_ff;
        din_meta_ff <= DATA_IN[7:0];
        din_ff      <= din_meta_ff;
        cfg_meta_ff <= {RGB_CFG_PIN_HI, RGB_CFG_PIN_LO};
        cfg_ff      <= cfg_meta_ff;
        por_meta_ff <= POWER_ON;
        por_ff      <= por_meta_ff;
        por_prev_ff <= por_ff;
    end

    // ==========================================================
    // Command decode
    // Data and the command select pass the same two stages as the
    // write strobe, and the edge pulse comes from the second stage, so both
    // reach logic in the same cycle the end of a write is seen, with no extra
    // margin. The host must still hold them two cycles past the strobe for that reason.
    wire       cmd_wr = wr_rise & ~dcx_ff;
    wire [7:0] opcode = din_ff;
    wire       por_pulse = por_ff & ~por_prev_ff;

    // Read sequence states; the binary codes live in the shared header
    localparam [1:0] PH_IDLE  = `RD_PHASE_IDLE;
    localparam [1:0] PH_DUMMY = `RD_PHASE_DUMMY;
    localparam [1:0] PH_ID    = `RD_PHASE_ID;
    localparam [1:0] PH_DONE  = `RD_PHASE_DONE;

    reg  [1:0] phase_ff;
    reg  [7:0] id_sel_ff;
    reg  [1:0] nxt_phase;
    reg  [7:0] nxt_id_sel;

    // No display-mode input gates decoding: all states accept these.
    // Any other opcode, the gamma ones included, closes an open read
    // sequence, so a stale ID byte can never be read after it.
    always @* begin
        nxt_phase  = phase_ff;
        nxt_id_sel = id_sel_ff;
        if (cmd_wr) begin
            case (opcode)
                // ID bytes are parameters, so no reset or write alters them
                `OP_READ_MAKER_ID: begin
                    nxt_phase  = PH_DUMMY;
                    nxt_id_sel = MAKER_ID;
                end
                `OP_READ_VERSION_ID: begin
                    nxt_phase  = PH_DUMMY;
                    nxt_id_sel = VERSION_ID;
                end
                `OP_READ_PART_ID: begin
                    nxt_phase  = PH_DUMMY;
                    nxt_id_sel = PART_ID;
                end
                default: begin
                    nxt_phase = PH_IDLE;
                end
            endcase
        end else if (rd_rise && dcx_ff) begin
            // Advance after each completed read cycle; once done, further
            // reads leave the bus undriven until the next command
            case (phase_ff)
                PH_DUMMY: nxt_phase = PH_ID;
                PH_ID:    nxt_phase = PH_DONE;
                default:  nxt_phase = phase_ff;
            endcase
        end
    end

    // ID select starts at zero; only a read command loads it
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            phase_ff  <= PH_IDLE;
            id_sel_ff <= 8'h00;
        end else begin
            phase_ff  <= nxt_phase;
            id_sel_ff <= nxt_id_sel;
        end
    end

    // ==========================================================
    // Read data driver: dummy byte first, ID byte second.
    // The byte is loaded at the start of a read and left standing, so a
    // slow host still sees it; only the enable drops once the read ends.
    // Reads with the command select low are not ours and drive nothing.
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            DATA_OUT <= 8'h00;
            DATA_OE  <= 1'b0;
        end else if (rd_fall && dcx_ff && phase_ff == PH_DUMMY) begin
            DATA_OUT <= `DUMMY_BYTE;
            DATA_OE  <= 1'b1;
        end else if (rd_fall && dcx_ff && phase_ff == PH_ID) begin
            DATA_OUT <= id_sel_ff;
            DATA_OE  <= 1'b1;
        end else if (rd_level) begin
            DATA_OE  <= 1'b0;
        end
    end

    // ==========================================================
    // Split gamma state
    // RST_N is the hardware reset; power-on takes the strap pins:
    // "00" gives off, "1x" gives on, "01" keeps it off as well.
    // Both straps are decoded in full, so only a high upper strap
    // can turn split curves on at power-on.
    reg        strap_gamma;

    always @* begin
        strap_gamma = 1'b0;
        case (cfg_ff)
            2'h0:    strap_gamma = 1'b0;
            2'h1:    strap_gamma = 1'b0;
            default: strap_gamma = 1'b1;
        endcase
    end

    // Priority is hardware reset, then power-on, then host commands;
    // an off command when already off simply rewrites the same value.
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            SPLIT_GAMMA_EN <= `SPLIT_GAMMA_HW_RESET;
        end else if (por_pulse) begin
            SPLIT_GAMMA_EN <= strap_gamma;
        end else if (cmd_wr && opcode == `OP_SOFT_RESET) begin
            SPLIT_GAMMA_EN <= `SPLIT_GAMMA_SW_RESET;
        end else if (cmd_wr && opcode == `OP_SPLIT_GAMMA_OFF) begin
            SPLIT_GAMMA_EN <= 1'b0;
        end else if (cmd_wr && opcode == `OP_SPLIT_GAMMA_ON) begin
            SPLIT_GAMMA_EN <= 1'b1;
        end
    end

    // Only curve zero (2.2) is ever split into R, G and B.
    // It follows the enable one cycle late, so the curve select always
    // sees a settled state, never one mid-way through a command.
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            GAMMA_CURVE_ZERO_SPLIT <= 1'b0;
        end else begin
            GAMMA_CURVE_ZERO_SPLIT <= SPLIT_GAMMA_EN;
        end
    end
endmodule
`default_nettype wire

/* File: logic/idcmd_regs.vh */
`ifndef IDCMD_REGS_VH
`define IDCMD_REGS_VH
// ==========================================================
// Command opcodes
`define OP_READ_MAKER_ID       8'hDA
`define OP_READ_VERSION_ID     8'hDB
`define OP_READ_PART_ID        8'hDC
`define OP_SPLIT_GAMMA_OFF     8'hAA
`define OP_SPLIT_GAMMA_ON      8'hAB
`define OP_SOFT_RESET          8'h01
// ==========================================================
// Read sequence phases
`define RD_PHASE_DUMMY         2'h1
`define RD_PHASE_ID            2'h2
`define RD_PHASE_DONE          2'h3
`define RD_PHASE_IDLE          2'h0
// ==========================================================
// Split gamma defaults and dummy read byte
`define SPLIT_GAMMA_HW_RESET   1'b1
`define SPLIT_GAMMA_SW_RESET   1'b0
`define DUMMY_BYTE             8'h00
`endif

/* File: logic/strobe_sync.v */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Two-stage synchroniser plus falling/rising edge pulses
module strobe_sync (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       async_in,
    output reg        level_ff,
    output wire       rise,
    output wire       fall
);
    reg meta_ff;
    reg prev_ff;

    // Only the second stage and later feed logic
    always @(posedge clk) begin
        if (!rst_n) begin
            meta_ff  <= 1'b1;
            level_ff <= 1'b1;
            prev_ff  <= 1'b1;
        end else begin
            meta_ff  <= async_in;
            level_ff <= meta_ff;
            prev_ff  <= level_ff;
        end
    end

    assign rise = level_ff & ~prev_ff;
    assign fall = ~level_ff & prev_ff;
endmodule
`default_nettype wire

/* File: bench/idrb_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Port checks
module idrb_asserts (
    input wire logic       REF_CLK,
    input wire logic       RST_N,
    input wire logic       CMD_DATA_SELECT,
    input wire logic       READ_STROBE_N,
    input wire logic       RGB_CFG_PIN_HI,
    input wire logic [7:0] DATA_OUT,
    input wire logic       DATA_OE,
    input wire logic       SPLIT_GAMMA_EN,
    input wire logic       GAMMA_CURVE_ZERO_SPLIT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // Long idle read strobe, then a driven byte held
    sequence rd_idle; READ_STROBE_N [*5]; endsequence
    sequence oe_held; DATA_OE [*3]; endsequence
    chk_curve_track: assert property ($past(RST_N) |->
        GAMMA_CURVE_ZERO_SPLIT == $past(SPLIT_GAMMA_EN)) else $error("curve lag");
    chk_oe_cause: assert property ($rose(DATA_OE) |->
        !READ_STROBE_N && !$past(READ_STROBE_N, 2)) else $error("oe cause");
    chk_oe_stands: assert property ($rose(DATA_OE) |=> oe_held) else $error("oe short");
    chk_oe_release: assert property ($rose(READ_STROBE_N) |-> ##[1:4] !DATA_OE)
        else $error("oe stuck");
    chk_idle_quiet: assert property (rd_idle |-> !DATA_OE) else $error("oe idle");
    chk_out_moves: assert property ($changed(DATA_OUT) |-> !READ_STROBE_N)
        else $error("out moved");
    chk_gamma_on: assert property ($rose(SPLIT_GAMMA_EN) |->
        !CMD_DATA_SELECT || RGB_CFG_PIN_HI) else $error("gamma rose");
    chk_gamma_off: assert property ($fell(SPLIT_GAMMA_EN) |->
        !CMD_DATA_SELECT || !RGB_CFG_PIN_HI) else $error("gamma fell");
endmodule
bind id_readback_and_gamma_split_off idrb_asserts chk (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .CMD_DATA_SELECT(CMD_DATA_SELECT), .READ_STROBE_N(READ_STROBE_N),
    .RGB_CFG_PIN_HI(RGB_CFG_PIN_HI), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
    .SPLIT_GAMMA_EN(SPLIT_GAMMA_EN), .GAMMA_CURVE_ZERO_SPLIT(GAMMA_CURVE_ZERO_SPLIT));
`default_nettype wire

/* File: bench/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Host side: strobes move on falling edges, write held 4 cycles, read held 5
module host_model (
    input wire logic        clk,
    input wire logic [7:0]  q_in,
    input wire logic        oe_in,
    output logic            dc = 1'b1,
    output logic            wr_n = 1'b1,
    output logic            rd_n = 1'b1,
    output logic [17:0]     dat = 18'h00000
);
    task wr(input logic d_c, input logic [7:0] b);
        @(negedge clk);
        dc = d_c;
        // Upper lines copy bit 0, so both of their levels are exercised
        dat = {{10{b[0]}}, b};
        wr_n = 1'b0;
        repeat (4) @(negedge clk);
        wr_n = 1'b1;
        repeat (4) @(negedge clk);
        dat = ~dat; // Stale byte never lingers
    endtask
    task rd(output logic [7:0] q, output logic oe);
        @(negedge clk);
        dc = 1'b1;
        rd_n = 1'b0;
        repeat (5) @(negedge clk);
        q = q_in;
        oe = oe_in;
        rd_n = 1'b1;
        repeat (5) @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* File: bench/id_readback_and_gamma_split_off_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// Bench
module id_readback_and_gamma_split_off_tb;
    localparam logic [7:0] MK = 8'h5A; // Arbitrary
    localparam logic [7:0] VR = 8'hA5; // Arbitrary
    localparam logic [7:0] PT = 8'hC3; // Arbitrary
    logic clk = 1'b0, rst_n = 1'b0, pwr = 1'b0, hi = 1'b0, lo = 1'b0;
    logic dc, wr_n, rd_n, oe, sg, gcz;
    logic [17:0] dat;
    logic [7:0] dout;
    int errors = 0, comparisons = 0;
    always #10 clk = ~clk;
    host_model h (.clk(clk), .q_in(dout), .oe_in(oe), .dc(dc), .wr_n(wr_n), .rd_n(rd_n),
        .dat(dat));
    id_readback_and_gamma_split_off #(.MAKER_ID(MK), .VERSION_ID(VR), .PART_ID(PT)) uut (
        .REF_CLK(clk), .RST_N(rst_n), .POWER_ON(pwr), .CMD_DATA_SELECT(dc),
        .WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n), .DATA_IN(dat), .RGB_CFG_PIN_HI(hi),
        .RGB_CFG_PIN_LO(lo), .DATA_OUT(dout), .DATA_OE(oe), .SPLIT_GAMMA_EN(sg),
        .GAMMA_CURVE_ZERO_SPLIT(gcz));
    task check(string what, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task hw_reset;
        @(negedge clk);
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        check("reset_gamma", 8'h01, {7'h00, sg});
        check("reset_oe", 8'h00, {7'h00, oe});
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        check("reset_curve", 8'h01, {7'h00, gcz});
    endtask
    // Dummy first, then the byte, then nothing driven
    task t_id(input logic [7:0] op, input logic [7:0] exp);
        logic [7:0] q;
        logic e;
        h.wr(1'b0, op);
        h.rd(q, e);
        check("dummy", 8'h00, q);
        check("dummy_oe", 8'h01, {7'h00, e});
        h.rd(q, e);
        check("id", exp, q);
        check("id_oe", 8'h01, {7'h00, e});
        h.rd(q, e);
        check("third_oe", 8'h00, {7'h00, e});
    endtask
    task t_gamma(input logic [7:0] op, input logic exp);
        h.wr(1'b0, op);
        repeat (2) @(negedge clk);
        check("gamma", {7'h00, exp}, {7'h00, sg});
        check("curve", {7'h00, exp}, {7'h00, gcz});
    endtask
    // Power-on edge must pass the synchroniser before the strap is used
    task t_power(input logic h_i, input logic l_o, input logic exp);
        @(negedge clk);
        hi = h_i;
        lo = l_o;
        pwr = 1'b1;
        repeat (6) @(negedge clk);
        pwr = 1'b0;
        check("strap", {7'h00, exp}, {7'h00, sg});
        repeat (4) @(negedge clk);
    endtask
    task results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        results;
    end
    initial begin
        hw_reset;
        t_id(8'hDA, MK);
        t_id(8'hDB, VR);
        t_id(8'hDC, PT);
        t_gamma(8'hAA, 1'b0);
        t_gamma(8'hAA, 1'b0);
        t_gamma(8'hAB, 1'b1);
        t_gamma(8'h01, 1'b0);
        t_id(8'hDA, MK);
        t_power(1'b1, 1'b0, 1'b1);
        t_power(1'b0, 1'b1, 1'b0);
        t_power(1'b1, 1'b1, 1'b1);
        t_power(1'b0, 1'b0, 1'b0);
        hw_reset;
        t_id(8'hDB, VR);
        results;
    end
endmodule
`default_nettype wire
